// ===== common/rsc_pkg.sv
// constants, register map and state codes of the reset and stop-recovery controller
// assumes one 40 MHz clock; the watchdog oscillator is an enable pulse divided from pclk by WDT_OSC_DIV
package rsc_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 25000;
  localparam int unsigned OSC_HOLD_CYC = 66;
  localparam int unsigned SYSCLK_HOLD_CYC = 16;
  localparam int unsigned EXT_FILTER_CYC = 4;
  localparam int unsigned WAKE_FILTER_NS = 10;
  // shortest time rounds down, never below one cycle
  localparam int unsigned WAKE_FILTER_RAW = (WAKE_FILTER_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned WAKE_FILTER_CYC = (WAKE_FILTER_RAW == 0) ? 1 : WAKE_FILTER_RAW;
  localparam int unsigned WDT_OSC_DIV_DEF = 40;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_WDCTL = 8'h00;
  localparam logic [7:0] ADDR_DBGCTL = 8'h04;
  localparam logic [7:0] ADDR_OPTION = 8'h08;
  localparam logic [7:0] ADDR_WAKE_EN = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // watchdog_control_reg flag positions
  localparam int unsigned FLAG_EXT = 4;
  localparam int unsigned FLAG_WDT = 5;
  localparam int unsigned FLAG_STOP = 6;
  localparam int unsigned FLAG_POR = 7;
  localparam logic [7:0] WDCTL_RESET = 8'h80;

  // debugger_control_reg and option fields
  localparam int unsigned DBG_RST_BIT = 0;
  localparam int unsigned OPT_WDT_RESET_BIT = 0;
  localparam int unsigned OPT_BO_STOP_BIT = 1;
  localparam logic OPT_WDT_RESET_DEF = 1'b1;
  localparam logic OPT_BO_STOP_DEF = 1'b0;
  localparam logic [7:0] WAKE_EN_RESET = 8'h00;

  // reset vector locations
  localparam logic [15:0] VEC_ADDR_LO = 16'h0002;
  localparam logic [15:0] VEC_ADDR_HI = 16'h0003;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_RUN      = 6'h01,
    ST_STOP     = 6'h02,
    ST_HOLD_OSC = 6'h04,
    ST_HOLD_CLK = 6'h08,
    ST_VEC_LO   = 6'h10,
    ST_VEC_HI   = 6'h20
  } rsc_state_e;

endpackage

// ===== core/rsc_hold_counter.sv
// saturating hold counter with a pulse on its final tick
// assumes tick is a one-cycle enable in the pclk domain
`timescale 1ns/1ps
`default_nettype none
module rsc_hold_counter #(
  parameter int unsigned N = 16,
  parameter int unsigned W = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clr,
  input wire logic tick,
  output logic expire,
  output logic done
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } rsc_cnt_s;

  rsc_cnt_s cur_ff;
  rsc_cnt_s nxt_ff;

  always_comb begin
    nxt_ff = cur_ff;
    if (clr) begin
      nxt_ff.cnt = '0;
    end else if (tick && (cur_ff.cnt != W'(N))) begin
      nxt_ff.cnt = cur_ff.cnt + W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // no clr term: keeps the parent's clear decision out of a combinational loop
  assign expire = tick && (cur_ff.cnt == W'(N - 1));
  assign done = (cur_ff.cnt == W'(N));

endmodule
`default_nettype wire

// ===== core/rsc_level_filter.sv
// level filter: output rises after N consecutive high samples, falls at once
// assumes the input is already synchronous to pclk
`timescale 1ns/1ps
`default_nettype none
module rsc_level_filter #(
  parameter int unsigned N = 4,
  parameter int unsigned W = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic level,
  output logic filtered
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic out;
  } rsc_filt_s;

  rsc_filt_s cur_ff;
  rsc_filt_s nxt_ff;

  always_comb begin
    nxt_ff = cur_ff;
    if (!level) begin
      nxt_ff.cnt = '0;
    end else if (cur_ff.cnt != W'(N)) begin
      nxt_ff.cnt = cur_ff.cnt + W'(1);
    end
    nxt_ff.out = level && (nxt_ff.cnt == W'(N));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign filtered = cur_ff.out;

endmodule
`default_nettype wire

// ===== core/rsc_reset_ctrl.sv
// reset and stop-recovery sequencer with its apb register file
// assumes all inputs synchronous to pclk; presetn is the true power-on reset
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_ctrl #(
  parameter int unsigned WDT_OSC_DIV = rsc_pkg::WDT_OSC_DIV_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic supply_low,
  input wire logic brownout_low,
  input wire logic wdt_timeout,
  input wire logic ext_reset_n,
  input wire logic debug_pin_n,
  input wire logic [7:0] gpio_in,
  input wire logic stop_req,
  input wire logic irq_enabled,
  output logic sys_reset_n,
  output logic cpu_hold,
  output logic sysclk_en,
  output logic gpio_force_input,
  output logic pullup_disable,
  output logic [7:0] port_input_capture,
  output logic [7:0] pin_wake_irq,
  output logic wdt_irq,
  output logic vector_fetch,
  output logic [15:0] vector_addr
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    rsc_pkg::rsc_state_e state;
    logic sys_kind;
    logic [7:0] div_cnt;
    logic osc_tick;
    logic [7:0] wd_flags;
    logic dbg_rst;
    logic opt_wdt_reset;
    logic opt_bo_stop;
    logic [7:0] wake_en;
    logic [7:0] stop_level;
    logic wdt_wake;
    logic sys_reset_n;
    logic cpu_hold;
    logic sysclk_en;
    logic gpio_force_input;
    logic pullup_disable;
    logic [7:0] port_data;
    logic [7:0] pin_irq;
    logic wdt_irq;
    logic vec_fetch;
    logic [15:0] vec_addr;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } rsc_ctrl_s;

  rsc_ctrl_s cur_ff;
  rsc_ctrl_s nxt_ff;

  logic ext_low;
  logic wake_seen;
  logic osc_expire;
  logic clk_expire;
  logic clk_done;
  logic osc_clr;
  logic start_sys;
  logic [7:0] pin_diff;

  // ----------------------------------------------------------------
  // filters and hold counters
  // ----------------------------------------------------------------
  assign pin_diff = (gpio_in ^ cur_ff.stop_level) & cur_ff.wake_en;

  // short pin pulses never start the sequence
  rsc_level_filter #(.N(rsc_pkg::EXT_FILTER_CYC), .W(3)) u_ext_filter (
    .pclk(pclk),
    .presetn(presetn),
    .level(!ext_reset_n),
    .filtered(ext_low)
  );

  // sampling at 25 ns already drops sub-period glitches
  rsc_level_filter #(.N(rsc_pkg::WAKE_FILTER_CYC), .W(2)) u_wake_filter (
    .pclk(pclk),
    .presetn(presetn),
    .level((cur_ff.state == rsc_pkg::ST_STOP) && (|pin_diff)),
    .filtered(wake_seen)
  );

  rsc_hold_counter #(.N(rsc_pkg::OSC_HOLD_CYC), .W(7)) u_osc_count (
    .pclk(pclk),
    .presetn(presetn),
    .clr(osc_clr),
    .tick(cur_ff.osc_tick),
    .expire(osc_expire),
    .done()
  );

  rsc_hold_counter #(.N(rsc_pkg::SYSCLK_HOLD_CYC), .W(5)) u_clk_count (
    .pclk(pclk),
    .presetn(presetn),
    .clr(cur_ff.state != rsc_pkg::ST_HOLD_CLK),
    .tick(1'b1),
    .expire(clk_expire),
    .done(clk_done)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic in_hold;
    logic stop_ctx;
    logic supply_fault;
    logic stop_event;
    logic [7:0] flag_set;
    logic [7:0] flag_clr;
    logic sys_start_req;
    logic acc;
    in_hold = 1'b0;
    stop_ctx = 1'b0;
    supply_fault = 1'b0;
    stop_event = 1'b0;
    flag_set = 8'h00;
    flag_clr = 8'h00;
    sys_start_req = 1'b0;
    acc = 1'b0;
    nxt_ff = cur_ff;
    start_sys = 1'b0;
    osc_clr = 1'b0;

    // oscillator tick divider
    if (cur_ff.div_cnt == 8'(WDT_OSC_DIV - 1)) begin
      nxt_ff.div_cnt = 8'h00;
      nxt_ff.osc_tick = 1'b1;
    end else begin
      nxt_ff.div_cnt = cur_ff.div_cnt + 8'h01;
      nxt_ff.osc_tick = 1'b0;
    end

    in_hold = (cur_ff.state == rsc_pkg::ST_HOLD_OSC) || (cur_ff.state == rsc_pkg::ST_HOLD_CLK);
    stop_ctx = (cur_ff.state == rsc_pkg::ST_STOP) || (in_hold && !cur_ff.sys_kind);
    supply_fault = supply_low || (brownout_low && (!stop_ctx || cur_ff.opt_bo_stop));

    // apb slave, no wait states
    nxt_ff.pready = psel && !penable && !cur_ff.pready;
    acc = psel && penable && cur_ff.pready;
    if (psel && !penable) begin
      nxt_ff.pslverr = 1'b0;
      nxt_ff.prdata = 32'h0000_0000;
      unique case (paddr)
        rsc_pkg::ADDR_WDCTL: nxt_ff.prdata = {24'h00_0000, cur_ff.wd_flags};
        rsc_pkg::ADDR_DBGCTL: nxt_ff.prdata = {31'h0000_0000, cur_ff.dbg_rst};
        rsc_pkg::ADDR_OPTION: nxt_ff.prdata = {30'h0000_0000, cur_ff.opt_bo_stop,
                                               cur_ff.opt_wdt_reset};
        rsc_pkg::ADDR_WAKE_EN: nxt_ff.prdata = {24'h00_0000, cur_ff.wake_en};
        rsc_pkg::ADDR_STATUS: nxt_ff.prdata = {17'h0_0000, cur_ff.port_data,
                                               cur_ff.sys_kind, cur_ff.state};
        default: nxt_ff.pslverr = 1'b1;
      endcase
    end
    if (!(psel && !penable)) begin
      nxt_ff.pslverr = 1'b0;
    end
    if (acc && pwrite) begin
      unique case (paddr)
        rsc_pkg::ADDR_WDCTL: flag_clr = pwdata[7:0];
        rsc_pkg::ADDR_DBGCTL: nxt_ff.dbg_rst = pwdata[rsc_pkg::DBG_RST_BIT];
        rsc_pkg::ADDR_OPTION: begin
          nxt_ff.opt_wdt_reset = pwdata[rsc_pkg::OPT_WDT_RESET_BIT];
          nxt_ff.opt_bo_stop = pwdata[rsc_pkg::OPT_BO_STOP_BIT];
        end
        rsc_pkg::ADDR_WAKE_EN: nxt_ff.wake_en = pwdata[7:0];
        default: ;
      endcase
    end

    // reset sources, strongest first
    nxt_ff.wdt_irq = 1'b0;
    nxt_ff.pin_irq = 8'h00;
    nxt_ff.vec_fetch = 1'b0;
    if (supply_fault) begin
      sys_start_req = 1'b1;
      flag_set[rsc_pkg::FLAG_POR] = 1'b1;
    end else if (ext_low && !(in_hold && cur_ff.sys_kind)) begin
      sys_start_req = 1'b1;
      flag_set[rsc_pkg::FLAG_EXT] = 1'b1;
    end else if (cur_ff.dbg_rst && !in_hold) begin
      sys_start_req = 1'b1;
      flag_set[rsc_pkg::FLAG_POR] = 1'b1;
    end else if ((cur_ff.state == rsc_pkg::ST_RUN) && wdt_timeout) begin
      if (cur_ff.opt_wdt_reset) begin
        sys_start_req = 1'b1;
        flag_set[rsc_pkg::FLAG_WDT] = 1'b1;
      end else begin
        nxt_ff.wdt_irq = 1'b1;
      end
    end else if (cur_ff.state == rsc_pkg::ST_STOP) begin
      if (wdt_timeout) begin
        stop_event = 1'b1;
        nxt_ff.wdt_wake = 1'b1;
        flag_set[rsc_pkg::FLAG_WDT] = 1'b1;
      end else if (wake_seen || !debug_pin_n) begin
        stop_event = 1'b1;
      end
      if (stop_event) begin
        flag_set[rsc_pkg::FLAG_STOP] = 1'b1;
      end
    end

    start_sys = sys_start_req;
    if (sys_start_req && !(in_hold && cur_ff.sys_kind && (flag_set == 8'h00))) begin
      // a fresh system reset reports only its own cause
      nxt_ff.wd_flags = flag_set;
    end else begin
      // hardware set wins over a software clear in the same cycle
      nxt_ff.wd_flags = (cur_ff.wd_flags & ~flag_clr) | flag_set;
    end

    // sequencer
    unique case (cur_ff.state)
      rsc_pkg::ST_RUN: begin
        if (stop_req) begin
          nxt_ff.state = rsc_pkg::ST_STOP;
          nxt_ff.stop_level = gpio_in;
          nxt_ff.wdt_wake = 1'b0;
        end
      end
      rsc_pkg::ST_STOP: begin
        if (stop_event) begin
          nxt_ff.state = rsc_pkg::ST_HOLD_OSC;
          nxt_ff.sys_kind = 1'b0;
        end
      end
      rsc_pkg::ST_HOLD_OSC: begin
        if (osc_expire) begin
          nxt_ff.state = rsc_pkg::ST_HOLD_CLK;
        end
      end
      rsc_pkg::ST_HOLD_CLK: begin
        if ((clk_expire || clk_done) && !ext_low) begin
          nxt_ff.state = rsc_pkg::ST_VEC_LO;
          nxt_ff.vec_fetch = 1'b1;
          nxt_ff.vec_addr = rsc_pkg::VEC_ADDR_LO;
          nxt_ff.port_data = gpio_in;
          if (!cur_ff.sys_kind) begin
            nxt_ff.pin_irq = pin_diff;
            nxt_ff.wdt_irq = cur_ff.wdt_wake && !cur_ff.opt_wdt_reset && irq_enabled;
          end
        end
      end
      rsc_pkg::ST_VEC_LO: begin
        nxt_ff.state = rsc_pkg::ST_VEC_HI;
        nxt_ff.vec_fetch = 1'b1;
        nxt_ff.vec_addr = rsc_pkg::VEC_ADDR_HI;
      end
      rsc_pkg::ST_VEC_HI: begin
        nxt_ff.state = rsc_pkg::ST_RUN;
      end
      default: begin
        nxt_ff.state = rsc_pkg::ST_HOLD_OSC;
        nxt_ff.sys_kind = 1'b1;
      end
    endcase

    // system reset restarts the full count; supply fault keeps it pinned
    if (start_sys) begin
      nxt_ff.state = rsc_pkg::ST_HOLD_OSC;
      nxt_ff.sys_kind = 1'b1;
      nxt_ff.dbg_rst = 1'b0;
      nxt_ff.wdt_wake = 1'b0;
      nxt_ff.vec_fetch = 1'b0;
      nxt_ff.pin_irq = 8'h00;
      nxt_ff.wdt_irq = 1'b0;
    end
    osc_clr = (cur_ff.state != rsc_pkg::ST_HOLD_OSC) || start_sys;

    // output decode from the next state
    nxt_ff.cpu_hold = (nxt_ff.state == rsc_pkg::ST_HOLD_OSC) ||
                      (nxt_ff.state == rsc_pkg::ST_HOLD_CLK);
    // stop recovery leaves peripherals and registers alone
    nxt_ff.sys_reset_n = !(nxt_ff.cpu_hold && nxt_ff.sys_kind);
    nxt_ff.gpio_force_input = !nxt_ff.sys_reset_n;
    nxt_ff.pullup_disable = !nxt_ff.sys_reset_n;
    nxt_ff.sysclk_en = (nxt_ff.state != rsc_pkg::ST_HOLD_OSC) &&
                       (nxt_ff.state != rsc_pkg::ST_STOP);
    // input capture frozen in stop and throughout the hold
    if ((cur_ff.state == rsc_pkg::ST_RUN) && (nxt_ff.state == rsc_pkg::ST_RUN)) begin
      nxt_ff.port_data = gpio_in;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // options and wake_en live only on presetn; dbg_rst is cleared
  // by every system reset, including the one it requests
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_ff <= '0;
      cur_ff.state <= rsc_pkg::ST_HOLD_OSC;
      cur_ff.sys_kind <= 1'b1;
      cur_ff.wd_flags <= rsc_pkg::WDCTL_RESET;
      cur_ff.opt_wdt_reset <= rsc_pkg::OPT_WDT_RESET_DEF;
      cur_ff.opt_bo_stop <= rsc_pkg::OPT_BO_STOP_DEF;
      cur_ff.wake_en <= rsc_pkg::WAKE_EN_RESET;
      cur_ff.cpu_hold <= 1'b1;
      cur_ff.gpio_force_input <= 1'b1;
      cur_ff.pullup_disable <= 1'b1;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign prdata = cur_ff.prdata;
  assign pready = cur_ff.pready;
  assign pslverr = cur_ff.pslverr;
  assign sys_reset_n = cur_ff.sys_reset_n;
  assign cpu_hold = cur_ff.cpu_hold;
  assign sysclk_en = cur_ff.sysclk_en;
  assign gpio_force_input = cur_ff.gpio_force_input;
  assign pullup_disable = cur_ff.pullup_disable;
  assign port_input_capture = cur_ff.port_data;
  assign pin_wake_irq = cur_ff.pin_irq;
  assign wdt_irq = cur_ff.wdt_irq;
  assign vector_fetch = cur_ff.vec_fetch;
  assign vector_addr = cur_ff.vec_addr;

endmodule
`default_nettype wire

// ===== tb/rsc_pin_model.sv
// far-side pins: supply monitor, reset pin, debugger pin, watchdog, wake pins
// assumes each task is entered just after a rising edge of pclk
`timescale 1ns/1ps
`default_nettype none
module rsc_pin_model (
  input wire logic pclk,
  output logic supply_low,
  output logic brownout_low,
  output logic ext_reset_n,
  output logic debug_pin_n,
  output logic wdt_timeout,
  output logic [7:0] gpio_in
);
  initial begin
    supply_low = 1'b0;
    brownout_low = 1'b0;
    ext_reset_n = 1'b1;
    debug_pin_n = 1'b1;
    wdt_timeout = 1'b0;
    gpio_in = 8'h00;
  end
  // 0 pin, 1 debug, 2 supply, 3 brownout, 4 watchdog
  task automatic drive(input int sel, input logic on);
    case (sel)
      0: ext_reset_n <= !on;
      1: debug_pin_n <= !on;
      2: supply_low <= on;
      3: brownout_low <= on;
      default: wdt_timeout <= on;
    endcase
  endtask
  // pin low under four cycles is meant to be filtered away
  task automatic hold(input int sel, input int n);
    drive(sel, 1'b1);
    repeat (n) @(posedge pclk);
    drive(sel, 1'b0);
  endtask
  task automatic gpio(input logic [7:0] v);
    gpio_in <= v;
  endtask
endmodule
`default_nettype wire

// ===== tb/rsc_reset_ctrl_chk.sv
// timing checks on the reset controller ports
// assumes binding to rsc_reset_ctrl, pclk domain only
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_ctrl_chk #(
  parameter int unsigned WDT_OSC_DIV = 40
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic supply_low,
  input wire logic brownout_low,
  input wire logic ext_reset_n,
  input wire logic sys_reset_n,
  input wire logic cpu_hold,
  input wire logic sysclk_en,
  input wire logic gpio_force_input,
  input wire logic pullup_disable,
  input wire logic vector_fetch,
  input wire logic [15:0] vector_addr
);
  // ----------------------------------------------------------------
  // phase counters; saturate so a long pin hold cannot wrap
  // ----------------------------------------------------------------
  logic [15:0] osc_cnt_ff;
  logic [15:0] clk_cnt_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_cnt_ff <= 16'h0000;
      clk_cnt_ff <= 16'h0000;
    end else begin
      osc_cnt_ff <= (cpu_hold && !sysclk_en) ? osc_cnt_ff + {15'h0000, ~&osc_cnt_ff} : 16'h0000;
      clk_cnt_ff <= (cpu_hold && sysclk_en) ? clk_cnt_ff + {15'h0000, ~&clk_cnt_ff} : 16'h0000;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_osc_count: assert property ($rose(sysclk_en) && cpu_hold |-> osc_cnt_ff >= 65 * WDT_OSC_DIV)
    else $error("system clock started before oscillator count ended");
  a_clk_count: assert property ($fell(cpu_hold) |-> clk_cnt_ff >= 16)
    else $error("cpu released before sixteen clock cycles");
  a_cpu_idle: assert property (!sys_reset_n |-> cpu_hold && !vector_fetch)
    else $error("cpu not held during system reset");
  a_pins_input: assert property (gpio_force_input == !sys_reset_n && pullup_disable == !sys_reset_n)
    else $error("pins not forced to inputs during reset");
  a_supply_wins: assert property (supply_low |=> !sys_reset_n && cpu_hold)
    else $error("supply fault did not force reset");
  a_pin_holds: assert property ((!ext_reset_n)[*8] |-> !sys_reset_n)
    else $error("reset pin held low without reset");
  a_stop_keeps: assert property ((ext_reset_n && !supply_low && !brownout_low)[*3] ##0
    (cpu_hold && sys_reset_n) |=> sys_reset_n)
    else $error("stop recovery turned into system reset");
  a_vec_order: assert property ($rose(vector_fetch) |-> vector_addr == rsc_pkg::VEC_ADDR_LO
    ##1 vector_fetch && vector_addr == rsc_pkg::VEC_ADDR_HI ##1 !vector_fetch)
    else $error("vector fetch order wrong");
  a_vec_after: assert property ($rose(vector_fetch) |-> $past(cpu_hold) && !cpu_hold)
    else $error("vector fetch not at release");
  a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("apb ready not a single access cycle");
  a_err_zero: assert property (pready && pslverr |-> prdata == 32'h00000000)
    else $error("error response carried data");
endmodule
bind rsc_reset_ctrl rsc_reset_ctrl_chk #(.WDT_OSC_DIV(WDT_OSC_DIV)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .supply_low(supply_low), .brownout_low(brownout_low),
  .ext_reset_n(ext_reset_n), .sys_reset_n(sys_reset_n), .cpu_hold(cpu_hold),
  .sysclk_en(sysclk_en), .gpio_force_input(gpio_force_input),
  .pullup_disable(pullup_disable), .vector_fetch(vector_fetch), .vector_addr(vector_addr));
`default_nettype wire

// ===== tb/tb.sv
// register-level tests of the reset and stop-recovery controller
// assumes rsc_pin_model drives the far-side pins; oscillator divider cut to 2
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int unsigned DIV = 2;
  logic pclk, presetn, psel, penable, pwrite, stop_req, irq_enabled, pready, pslverr, er, wi;
  logic supply_low, brownout_low, wdt_timeout, ext_reset_n, debug_pin_n, wdt_irq;
  logic sys_reset_n, cpu_hold, sysclk_en, gpio_force_input, pullup_disable, vector_fetch;
  logic [7:0] paddr, gpio_in, port_input_capture, pin_wake_irq, wk;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] vector_addr;
  int miscompares, check_count, n;
  rsc_reset_ctrl #(.WDT_OSC_DIV(DIV)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .supply_low(supply_low), .brownout_low(brownout_low),
    .wdt_timeout(wdt_timeout), .ext_reset_n(ext_reset_n), .debug_pin_n(debug_pin_n),
    .gpio_in(gpio_in), .stop_req(stop_req), .irq_enabled(irq_enabled),
    .sys_reset_n(sys_reset_n), .cpu_hold(cpu_hold), .sysclk_en(sysclk_en),
    .gpio_force_input(gpio_force_input), .pullup_disable(pullup_disable),
    .port_input_capture(port_input_capture), .pin_wake_irq(pin_wake_irq), .wdt_irq(wdt_irq),
    .vector_fetch(vector_fetch), .vector_addr(vector_addr));
  rsc_pin_model pins (.pclk(pclk), .supply_low(supply_low), .brownout_low(brownout_low),
    .ext_reset_n(ext_reset_n), .debug_pin_n(debug_pin_n), .wdt_timeout(wdt_timeout),
    .gpio_in(gpio_in));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task final_report;
    if (miscompares == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // request stands until pready is seen high at a rising edge; an idle edge follows
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (k >= 20) begin
      miscompares++;
      final_report;
    end
  endtask
  task rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h00000000);
    chk(nm, rd, exp);
  endtask
  task wait_hold(input logic lvl);
    n = 0;
    do begin
      @(negedge pclk);
      wk |= pin_wake_irq;
      wi |= wdt_irq;
      n++;
    end while (cpu_hold !== lvl && n < 3000);
    @(posedge pclk);
    if (n >= 3000) begin
      miscompares++;
      final_report;
    end
  endtask
  task cycle_reset;
    wk = 8'h00;
    wi = 1'b0;
    wait_hold(1'b1);
    wait_hold(1'b0);
    chk("hold_len", {31'h0, n >= 65 * DIV + 16}, 32'h1);
  endtask
  task go_stop;
    apb(rsc_pkg::ADDR_WDCTL, 1'b1, 32'h000000F0);
    stop_req <= 1'b1;
    @(posedge pclk);
    stop_req <= 1'b0;
    @(posedge pclk);
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    stop_req = 1'b0;
    irq_enabled = 1'b0;
    miscompares = 0;
    check_count = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    cycle_reset;
    rdchk("wdctl_por", rsc_pkg::ADDR_WDCTL, 32'h00000080);
    rdchk("option_rst", rsc_pkg::ADDR_OPTION, 32'h00000001);
    rdchk("wake_en_rst", rsc_pkg::ADDR_WAKE_EN, 32'h00000000);
    apb(8'h14, 1'b0, 32'h00000000);
    chk("unmapped_err", {31'h0, er}, 32'h1);
    pins.gpio(8'hA5);
    repeat (3) @(posedge pclk);
    chk("capture", {24'h0, port_input_capture}, 32'h000000A5);
    pins.hold(0, 3);
    repeat (4) @(posedge pclk);
    chk("short_pin", {31'h0, cpu_hold}, 32'h0);
    // pin held past the normal time-out: release must end reset at once
    pins.hold(0, 300);
    wait_hold(1'b0);
    chk("late_release", {31'h0, n <= 4}, 32'h1);
    rdchk("wdctl_ext", rsc_pkg::ADDR_WDCTL, 32'h00000010);
    apb(rsc_pkg::ADDR_DBGCTL, 1'b1, 32'h00000001);
    cycle_reset;
    rdchk("dbg_clear", rsc_pkg::ADDR_DBGCTL, 32'h00000000);
    rdchk("wdctl_dbg", rsc_pkg::ADDR_WDCTL, 32'h00000080);
    pins.hold(4, 1);
    cycle_reset;
    rdchk("wdctl_wdt", rsc_pkg::ADDR_WDCTL, 32'h00000020);
    pins.hold(3, 5);
    cycle_reset;
    rdchk("wdctl_bo", rsc_pkg::ADDR_WDCTL, 32'h00000080);
    fork
      pins.hold(2, 10);
      pins.hold(0, 10);
    join
    cycle_reset;
    rdchk("wdctl_sup", rsc_pkg::ADDR_WDCTL, 32'h00000080);
    apb(rsc_pkg::ADDR_WAKE_EN, 1'b1, 32'h00000001);
    go_stop;
    pins.hold(3, 5);
    pins.gpio(8'hA7);
    repeat (4) @(posedge pclk);
    chk("stop_ignores", {31'h0, cpu_hold}, 32'h0);
    pins.gpio(8'hA6);
    cycle_reset;
    chk("wake_irq", {24'h0, wk}, 32'h00000001);
    rdchk("wdctl_pin", rsc_pkg::ADDR_WDCTL, 32'h00000040);
    rdchk("wake_keep", rsc_pkg::ADDR_WAKE_EN, 32'h00000001);
    apb(rsc_pkg::ADDR_OPTION, 1'b1, 32'h00000000);
    pins.hold(4, 1);
    @(posedge pclk);
    chk("wdt_irq_run", {31'h0, wdt_irq}, 32'h1);
    chk("wdt_no_reset", {31'h0, cpu_hold}, 32'h0);
    irq_enabled <= 1'b1;
    go_stop;
    pins.hold(4, 1);
    cycle_reset;
    chk("wdt_irq", {31'h0, wi}, 32'h1);
    rdchk("wdctl_swdt", rsc_pkg::ADDR_WDCTL, 32'h00000060);
    go_stop;
    pins.hold(1, 3);
    cycle_reset;
    rdchk("wdctl_dpin", rsc_pkg::ADDR_WDCTL, 32'h00000040);
    rdchk("status_run", rsc_pkg::ADDR_STATUS, 32'h00005301);
    apb(rsc_pkg::ADDR_OPTION, 1'b1, 32'h00000002);
    go_stop;
    pins.hold(3, 5);
    cycle_reset;
    rdchk("wdctl_bo_stop", rsc_pkg::ADDR_WDCTL, 32'h00000080);
    final_report;
  end
endmodule
`default_nettype wire
